/* sim/bbms_sequencer_bench.sv */
// Self-checking testbench for the backplane bus master sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "bbms_params.svh"
module bbms_sequencer_bench;
  import bbms_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, mode_temp = 1'b0, mode_dummy = 1'b0;
  logic hold_enable = 1'b0, ext_addr_en = 1'b0, stval_jumper = 1'b1, req_valid = 1'b0;
  logic instr_done = 1'b1, int_enable = 1'b0, int_req = 1'b0, nmi_req = 1'b0;
  logic phlda_pin = 1'b0, hold_ext_n = 1'b1, ack16 = 1'b1;
  logic [3:0]  my_prio = 4'h5, tma_ext_n = 4'hf;
  logic [7:0]  wait_cnt = 8'h00;
  logic [15:0] rd_word = 16'h6b1e;
  logic [4:0]  seen = 5'h00;
  bbms_req_t   req = '0;
  bbms_ctrl_t  ctrl;
  logic req_ready, int_accept, int_is_nmi, done, rdata_16, rdy_pin, sixtn_n_pin, hold_n_out;
  logic hold_n_oe, addr_hi_oe, stval_n_out, stval_n_oe, own_bus;
  logic [15:0] rdata, din_pin, dout;
  logic [3:0]  tma_n_out, tma_n_oe;
  logic [23:0] addr_out;
  logic [7:0]  status_out;
  int errors = 0, check_count = 0, lat0 = 0, lat = 0;
  wire hold_n_pin = ~hold_n_oe & hold_ext_n;
  wire [3:0] tma_n_pin = ~tma_n_oe & tma_ext_n;
  always #2 sys_clk = ~sys_clk;
  bbms_sequencer i_dut (.sys_clk(sys_clk), .nrst(nrst), .mode_temp(mode_temp),
    .mode_dummy(mode_dummy), .hold_enable(hold_enable), .ext_addr_en(ext_addr_en),
    .stval_jumper(stval_jumper), .my_prio(my_prio), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .instr_done(instr_done), .int_enable(int_enable),
    .int_req(int_req), .nmi_req(nmi_req), .int_accept(int_accept), .int_is_nmi(int_is_nmi),
    .done(done), .rdata(rdata), .rdata_16(rdata_16), .rdy_pin(rdy_pin),
    .sixtn_n_pin(sixtn_n_pin), .hold_n_pin(hold_n_pin), .phlda_pin(phlda_pin),
    .tma_n_pin(tma_n_pin), .din_pin(din_pin), .hold_n_out(hold_n_out), .hold_n_oe(hold_n_oe),
    .tma_n_out(tma_n_out), .tma_n_oe(tma_n_oe), .addr_out(addr_out), .addr_hi_oe(addr_hi_oe),
    .status_out(status_out), .dout(dout), .ctrl(ctrl), .stval_n_out(stval_n_out),
    .stval_n_oe(stval_n_oe), .own_bus(own_bus));
  bbms_slave_model i_slave (.sys_clk(sys_clk), .ctrl(ctrl), .wait_cnt(wait_cnt), .ack16(ack16),
    .rd_word(rd_word), .rdy_pin(rdy_pin), .sixtn_n_pin(sixtn_n_pin), .din_pin(din_pin));
  // ----------------------------------------------------------------
  // Monitors and shared tasks
  // ----------------------------------------------------------------
  always @(posedge sys_clk) seen <= seen | {int_accept, ctrl.hlda, ctrl.wr, ctrl.stval_n_drv, ctrl.sync};
  always @(negedge sys_clk) if (ctrl.sync === 1'b1) chk("stval_with_sync", 24'h0, {23'h0, ctrl.stval_n_drv});
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic too_long(input string nm);
    errors++;
    $display("MISMATCH %s expected event seen timeout", nm);
    tally_and_finish();
  endtask
  task automatic pass(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  task automatic do_reset;
    @(negedge sys_clk);
    nrst = 1'b0;
    pass(5);
    nrst = 1'b1;
    pass(8);
    seen = 5'h00;
  endtask
  // Waits on a sticky event bit; the bound keeps a hung design from stalling the run.
  task automatic wait_bit(input int k, input string nm);
    int n;
    n = 0;
    while (seen[k] !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 300) too_long(nm);
    end
  endtask
  task automatic run_cycle(input logic [23:0] a, input logic w, input logic ab);
    int n;
    @(negedge sys_clk);
    req = '{addr: a, status: 8'h3c, wdata: 16'hc3a5, write: w, abort: ab, ext_addr: 1'b0};
    req_valid = 1'b1;
    seen = 5'h00;
    // Let the combinational ready settle before it is looked at.
    #1;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 300) too_long("req_ready");
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    lat = 0;
    while (done !== 1'b1) begin
      @(negedge sys_clk);
      lat++;
      if (lat > 300) too_long("done");
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cycles;
    chk("ctrl_after_reset", 24'h0, {19'h0, ctrl});
    run_cycle(24'h00a55a, 1'b0, 1'b0);
    lat0 = lat;
    chk("rdata", {8'h0, rd_word}, {8'h0, rdata});
    chk("rdata_16", 24'h1, {23'h0, rdata_16});
    chk("sync_seen", 24'h1, {23'h0, seen[0]});
    chk("stval_seen", 24'h1, {23'h0, seen[1]});
    wait_cnt = 8'h03;
    ack16 = 1'b0;
    run_cycle(24'h001234, 1'b0, 1'b0);
    chk("wait_longer", 24'h1, {23'h0, lat > lat0});
    chk("rdata_8", 24'h0, {23'h0, rdata_16});
    wait_cnt = 8'hc8;
    run_cycle(24'h004321, 1'b0, 1'b1);
    chk("abort_lat", lat0, lat);
    wait_cnt = 8'h00;
    run_cycle(24'h00beef, 1'b1, 1'b0);
    chk("wr_seen", 24'h1, {23'h0, seen[2]});
    chk("dout", 24'h00c3a5, {8'h0, dout});
    chk("addr_lo", 24'h00beef, {8'h0, addr_out[15:0]});
  endtask
  task automatic t_hold;
    @(negedge sys_clk);
    hold_ext_n = 1'b0;
    pass(20);
    chk("hold_masked", 24'h0, {23'h0, seen[3]});
    wait_cnt = 8'h04;
    fork
      run_cycle(24'h000321, 1'b0, 1'b0);
      begin
        pass(3);
        hold_enable = 1'b1;
        int_req = 1'b1;
        int_enable = 1'b1;
      end
    join
    wait_cnt = 8'h00;
    wait_bit(3, "hlda");
    seen = 5'h00;
    pass(10);
    chk("hold_no_cycle", 24'h0, {23'h0, seen[0]});
    chk("hold_before_int", 24'h0, {23'h0, seen[4]});
    chk("hlda_held", 24'h1, {23'h0, ctrl.hlda});
    int_req = 1'b0;
    hold_ext_n = 1'b1;
    pass(8);
    chk("hlda_dropped", 24'h0, {23'h0, ctrl.hlda});
    run_cycle(24'h000777, 1'b0, 1'b0);
    chk("resume_rdata", {8'h0, rd_word}, {8'h0, rdata});
  endtask
  task automatic t_int;
    seen = 5'h00;
    int_enable = 1'b0;
    int_req = 1'b1;
    pass(20);
    chk("int_disabled", 24'h0, {23'h0, seen[4]});
    int_enable = 1'b1;
    wait_bit(4, "int_accept");
    int_req = 1'b0;
    pass(6);
    seen = 5'h00;
    nmi_req = 1'b1;
    wait_bit(4, "nmi_accept");
    chk("nmi_flag", 24'h1, {23'h0, int_is_nmi});
    nmi_req = 1'b0;
    pass(6);
  endtask
  task automatic t_temp(input logic [3:0] rival_n, input logic win);
    int n;
    mode_temp = 1'b1;
    tma_ext_n = rival_n;
    do_reset();
    req = '{addr: 24'h000abc, status: 8'h3c, wdata: 16'h1111, write: 1'b0, abort: 1'b0, ext_addr: 1'b0};
    req_valid = 1'b1;
    n = 0;
    while (hold_n_oe !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 300) too_long("hold_request");
    end
    pass(2);
    chk("tma_drive", 24'h5, {20'h0, tma_n_oe | {4{~win}} & 4'h5});
    phlda_pin = 1'b1;
    pass(10);
    chk("own_bus", {23'h0, win}, {23'h0, own_bus});
    if (win) begin
      run_cycle(24'h000abc, 1'b0, 1'b0);
      chk("addr_hi_oe", 24'h1, {23'h0, addr_hi_oe});
      chk("addr_hi_low", 24'h0, {16'h0, addr_out[23:16]});
      chk("stval_oe", 24'h1, {23'h0, stval_n_oe});
    end
    req_valid = 1'b0;
    phlda_pin = 1'b0;
    mode_temp = 1'b0;
    tma_ext_n = 4'hf;
  endtask
  task automatic t_dummy_and_reset;
    mode_dummy = 1'b1;
    do_reset();
    pass(20);
    chk("dummy_no_sync", 24'h0, {23'h0, seen[0]});
    chk("dummy_null", 24'h0, {19'h0, ctrl});
    hold_ext_n = 1'b0;
    pass(8);
    chk("dummy_grant", 24'h1, {23'h0, ctrl.hlda});
    hold_ext_n = 1'b1;
    pass(8);
    mode_dummy = 1'b0;
    do_reset();
    wait_cnt = 8'h32;
    req = '{addr: 24'h000999, status: 8'h3c, wdata: 16'h2222, write: 1'b1, abort: 1'b0, ext_addr: 1'b0};
    req_valid = 1'b1;
    wait_bit(0, "sync_before_reset");
    req_valid = 1'b0;
    pass(1);
    nrst = 1'b0;
    pass(2);
    chk("ctrl_in_reset", 24'h0, {19'h0, ctrl});
    wait_cnt = 8'h00;
    do_reset();
    run_cycle(24'h000555, 1'b0, 1'b0);
    chk("restart_rdata", {8'h0, rd_word}, {8'h0, rdata});
  endtask
  initial begin
    do_reset();
    t_cycles();
    t_hold();
    t_int();
    t_temp(4'hf, 1'b1);
    t_temp(4'h0, 1'b0);
    t_dummy_and_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* sim/bbms_slave_model.sv */
// Bus slave model that answers the master's cycles with ready, sixteen and read data.
`timescale 1ns/1ps
`default_nettype none
module bbms_slave_model (
  input  wire logic                 sys_clk,
  input  wire bbms_pkg::bbms_ctrl_t ctrl,
  input  wire logic [7:0]           wait_cnt,
  input  wire logic                 ack16,
  input  wire logic [15:0]          rd_word,
  output logic                      rdy_pin,
  output logic                      sixtn_n_pin,
  output logic [15:0]               din_pin
);
  import bbms_pkg::*;
  logic [7:0]  left_ff;
  logic [2:0]  sel_ff;
  logic [15:0] junk_ff;
  initial begin
    left_ff = 8'h00;
    sel_ff  = 3'h0;
    junk_ff = 16'h5a5a;
  end
  // ----------------------------------------------------------------
  // Ready and selection
  // ----------------------------------------------------------------
  // Ready drops for wait_cnt clocks after each cycle start.
  always_ff @(posedge sys_clk) begin
    if (ctrl.sync) left_ff <= wait_cnt;
    else if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
  end
  // The master sees pins two clocks late, so a slow slave keeps ready low between
  // cycles and raises it only once its count has run out under the strobes.
  assign rdy_pin = (wait_cnt == 8'h00) | ((left_ff == 8'h00) & (ctrl.wr | ctrl.dbin));
  // The slave stays selected a few clocks past the strobes, then lets go.
  always_ff @(posedge sys_clk) begin
    if (ctrl.sync | ctrl.stval_n_drv | ctrl.wr | ctrl.dbin | (left_ff != 8'h00)) sel_ff <= 3'h4;
    else if (sel_ff != 3'h0) sel_ff <= sel_ff - 3'h1;
  end
  // Released lines: data toggles so a stale value cannot match; sixteen is never released and always follows ack16.
  always_ff @(posedge sys_clk) begin
    junk_ff <= ~junk_ff;
  end
  // Sixteen is decoded statically, so it already stands when the master samples it.
  assign sixtn_n_pin = ~ack16;
  assign din_pin     = (ctrl.sync | (sel_ff != 3'h0)) ? rd_word : junk_ff;
endmodule
`default_nettype wire

/* verilog/bbms_params.svh */
// Timing counts and field constants for the backplane bus master sequencer.
`ifndef BBMS_PARAMS_SVH
`define BBMS_PARAMS_SVH
`define BBMS_CLK_PERIOD_NS   4
`define BBMS_ARB_MIN_NS      4
`define BBMS_ARB_CYCLES      ((`BBMS_ARB_MIN_NS + `BBMS_CLK_PERIOD_NS - 1) / `BBMS_CLK_PERIOD_NS)
`define BBMS_ADDR_W          24
`define BBMS_ADDR_LO_W       16
`define BBMS_DATA_W          16
`define BBMS_PRIO_W          4
`define BBMS_STAT_W          8
`define BBMS_CTRL_RST        5'h00
`define BBMS_HI_ADDR_ZERO    8'h00
`endif

/* verilog/bbms_pkg.sv */
// Types shared by the backplane bus master sequencer.
package bbms_pkg;
  typedef enum logic [2:0] {
    BBMS_START  = 3'b000,
    BBMS_STABLE = 3'b001,
    BBMS_WAIT   = 3'b010,
    BBMS_XFER   = 3'b011,
    BBMS_IDLE   = 3'b100,
    BBMS_HOLD   = 3'b101,
    BBMS_ARB    = 3'b110
  } bbms_state_t;

  // One bus cycle request from the core side.
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  status;
    logic [15:0] wdata;
    logic        write;
    logic        abort;
    logic        ext_addr;
  } bbms_req_t;

  // Control output strobes; all low is the null state.
  typedef struct packed {
    logic sync;
    logic stval_n_drv;
    logic wr;
    logic dbin;
    logic hlda;
  } bbms_ctrl_t;
endpackage

/* verilog/bbms_sequencer.sv */
// Bus cycle sequencer for a backplane master, permanent, dummy or temporary.
`timescale 1ns/1ps
`default_nettype none
`include "bbms_params.svh"

// Function
// - Raise sync in cycle start state as new address and status appear.
// - Assert status valid strobe in address stable state once outputs are stable.
// - Sample ready and sixteen acknowledge in stable state unless abort cycle.
// - Not ready enters wait state, resampled each clock until ready, then transfer.
// - Abort cycles ignore ready and never wait because of it.
// - Data exchange happens in transfer state after stable or last wait.
// - Zero or more idle states may follow transfer; none are guaranteed. Here at least one idle follows unless hold is taken.
// - Idle keeps write and read strobes off; no status valid with sync.
// - Hold acceptance can be disabled by an input for indivisible sequences.
// - Enabled hold request enters hold right after transfer and raises acknowledge.
// - Stay in hold without cycles until hold request drops, then resume.
// - Hold wins over a simultaneous interrupt at end of transfer.
// - Interrupt taken only with no hold, instruction done, enabled and requested; nonmaskable needs no enable.
// - Vectored interrupt may run an acknowledge cycle next; nonmaskable jumps.
// - Permanent master drives low address, optional upper byte, status, control, data.
// - Dummy master runs no cycles, holds null control except hlda while in hold, arbitrates at least one clock.
// - Temporary master capable units join priority arbitration among up to sixteen.
// - Drive priority, compare, release lower bits when higher priority is seen.
// - Requester left on arbitration lines takes the bus on acknowledge rising edge.
// - Temporary owner uses the same cycle states and runs any number of cycles.
// - Temporary owner drives upper address byte, low when not extended.
// - Status valid strobe driver can be disconnected by a jumper input.
// - Four open-collector arbitration lines carry encoded priority of requesters.
module bbms_sequencer (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic                     mode_temp,
  input  wire logic                     mode_dummy,
  input  wire logic                     hold_enable,
  input  wire logic                     ext_addr_en,
  input  wire logic                     stval_jumper,
  input  wire logic [`BBMS_PRIO_W-1:0]  my_prio,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire bbms_pkg::bbms_req_t      req,
  input  wire logic                     instr_done,
  input  wire logic                     int_enable,
  input  wire logic                     int_req,
  input  wire logic                     nmi_req,
  output logic                          int_accept,
  output logic                          int_is_nmi,
  output logic                          done,
  output logic [`BBMS_DATA_W-1:0]       rdata,
  output logic                          rdata_16,
  input  wire logic                     rdy_pin,
  input  wire logic                     sixtn_n_pin,
  input  wire logic                     hold_n_pin,
  input  wire logic                     phlda_pin,
  input  wire logic [`BBMS_PRIO_W-1:0]  tma_n_pin,
  input  wire logic [`BBMS_DATA_W-1:0]  din_pin,
  output logic                          hold_n_out,
  output logic                          hold_n_oe,
  output logic [`BBMS_PRIO_W-1:0]       tma_n_out,
  output logic [`BBMS_PRIO_W-1:0]       tma_n_oe,
  output logic [`BBMS_ADDR_W-1:0]       addr_out,
  output logic                          addr_hi_oe,
  output logic [`BBMS_STAT_W-1:0]       status_out,
  output logic [`BBMS_DATA_W-1:0]       dout,
  output bbms_pkg::bbms_ctrl_t          ctrl,
  output logic                          stval_n_out,
  output logic                          stval_n_oe,
  output logic                          own_bus
);
  import bbms_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Pins are asynchronous to this clock, so each passes two flops first.
  // Each resets to its idle level, so no false hold acknowledge edge follows reset.
  logic [7+`BBMS_DATA_W:0] pin_s1_ff;
  logic [7+`BBMS_DATA_W:0] pin_s2_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= {3'b111, 1'b0, {(`BBMS_PRIO_W+`BBMS_DATA_W){1'b1}}};
      pin_s2_ff <= {3'b111, 1'b0, {(`BBMS_PRIO_W+`BBMS_DATA_W){1'b1}}};
    end else begin
      pin_s1_ff <= {rdy_pin, sixtn_n_pin, hold_n_pin, phlda_pin, tma_n_pin, din_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  logic                    rdy_s, sixtn_s, hold_s, phlda_s;
  logic [`BBMS_PRIO_W-1:0] tma_s;
  logic [`BBMS_DATA_W-1:0] din_s;
  assign rdy_s   = pin_s2_ff[7+`BBMS_DATA_W];
  assign sixtn_s = ~pin_s2_ff[6+`BBMS_DATA_W];
  assign hold_s  = ~pin_s2_ff[5+`BBMS_DATA_W];
  assign phlda_s = pin_s2_ff[4+`BBMS_DATA_W];
  assign tma_s   = ~pin_s2_ff[3+`BBMS_DATA_W:`BBMS_DATA_W];
  assign din_s   = pin_s2_ff[`BBMS_DATA_W-1:0];

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  bbms_state_t state_ff, nxt_state;
  bbms_req_t   cur_ff;
  logic        phlda_d_ff;
  logic        have_req;
  logic        hold_take;
  logic        int_take;
  logic        arb_won;
  logic        phlda_rise;
  logic [1:0]  arb_cnt_ff;
  logic        boot_ff;
  bbms_req_t   nxt_cur;

  assign phlda_rise = phlda_s & ~phlda_d_ff;
  assign have_req   = req_valid & ~mode_dummy;
  // Hold beats interrupt; a disabled hold cannot break a locked sequence.
  assign hold_take  = ~mode_temp & hold_enable & hold_s;
  assign int_take   = ~mode_temp & ~mode_dummy & ~hold_take & instr_done
                      & ((int_enable & int_req) | nmi_req);
  assign arb_won    = (tma_s == my_prio);
  assign req_ready  = (state_ff == BBMS_IDLE) & have_req & ~hold_take & ~int_take;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BBMS_START: nxt_state = BBMS_STABLE;
      BBMS_STABLE: begin
        if (cur_ff.abort || rdy_s) begin
          nxt_state = BBMS_XFER;
        end else begin
          nxt_state = BBMS_WAIT;
        end
      end
      BBMS_WAIT: begin
        if (cur_ff.abort || rdy_s) begin
          nxt_state = BBMS_XFER;
        end
      end
      BBMS_XFER: begin
        if (hold_take) begin
          nxt_state = BBMS_HOLD;
        end else begin
          nxt_state = BBMS_IDLE;
        end
      end
      BBMS_IDLE: begin
        if (mode_temp) begin
          if (!have_req) begin
            nxt_state = BBMS_ARB;
          end else begin
            nxt_state = BBMS_START;
          end
        end else if (hold_take && (!mode_dummy || arb_cnt_ff >= 2'(`BBMS_ARB_CYCLES))) begin
          nxt_state = BBMS_HOLD;
        end else if (have_req && !int_take) begin
          nxt_state = BBMS_START;
        end
      end
      BBMS_HOLD: begin
        if (!hold_s) begin
          nxt_state = BBMS_IDLE;
        end
      end
      BBMS_ARB: begin
        if (have_req && arb_won && phlda_rise) begin
          nxt_state = BBMS_START;
        end
      end
      default: nxt_state = BBMS_START;
    endcase
    // A temporary master leaves reset without the bus; a dummy never runs a cycle.
    if ((mode_temp && boot_ff)
        || (mode_dummy && state_ff != BBMS_IDLE && state_ff != BBMS_HOLD)) begin
      nxt_state = mode_temp ? BBMS_ARB : BBMS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= BBMS_START;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Dummy master keeps the arbitration interval at least one clock.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_cnt_ff <= 2'b00;
    end else if (state_ff != BBMS_IDLE) begin
      arb_cnt_ff <= 2'b00;
    end else if (arb_cnt_ff != 2'b11) begin
      arb_cnt_ff <= arb_cnt_ff + 2'b01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phlda_d_ff <= 1'b0;
      boot_ff    <= 1'b1;
    end else begin
      phlda_d_ff <= phlda_s;
      boot_ff    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Cycle capture, data and interrupt outputs
  // ----------------------------------------------------------------
  // The bus outputs load at the edge that takes the request, so they read it through here.
  assign nxt_cur = (req_ready || (state_ff == BBMS_ARB && nxt_state == BBMS_START))
                   ? req : cur_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done       <= 1'b0;
      rdata      <= '0;
      rdata_16   <= 1'b0;
      int_accept <= 1'b0;
      int_is_nmi <= 1'b0;
    end else begin
      done       <= (state_ff == BBMS_XFER);
      int_accept <= (state_ff == BBMS_IDLE) & int_take;
      int_is_nmi <= (state_ff == BBMS_IDLE) & int_take & nmi_req;
      if (state_ff == BBMS_XFER && !cur_ff.write) begin
        rdata <= din_s;
      end
      if (state_ff == BBMS_STABLE && !cur_ff.abort) begin
        rdata_16 <= sixtn_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  logic in_cycle;
  assign in_cycle = (state_ff == BBMS_START) | (state_ff == BBMS_STABLE)
                    | (state_ff == BBMS_WAIT) | (state_ff == BBMS_XFER);
  assign own_bus  = ~mode_dummy & (~mode_temp | (state_ff != BBMS_ARB)) & (state_ff != BBMS_HOLD);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `BBMS_CTRL_RST;
    end else begin
      ctrl.sync        <= (nxt_state == BBMS_START) & ~mode_dummy;
      ctrl.stval_n_drv <= ((nxt_state == BBMS_STABLE) | (nxt_state == BBMS_WAIT))
                          & ~mode_dummy;
      ctrl.wr          <= cur_ff.write & ((nxt_state == BBMS_WAIT) | (nxt_state == BBMS_XFER))
                          & ~mode_dummy;
      ctrl.dbin        <= ~cur_ff.write & ((nxt_state == BBMS_WAIT) | (nxt_state == BBMS_XFER))
                          & ~mode_dummy;
      ctrl.hlda        <= (nxt_state == BBMS_HOLD) & ~mode_temp;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_out   <= '0;
      status_out <= '0;
      dout       <= '0;
    end else if (nxt_state == BBMS_START) begin
      addr_out[`BBMS_ADDR_LO_W-1:0] <= nxt_cur.addr[`BBMS_ADDR_LO_W-1:0];
      addr_out[`BBMS_ADDR_W-1:`BBMS_ADDR_LO_W] <= nxt_cur.ext_addr
          ? nxt_cur.addr[`BBMS_ADDR_W-1:`BBMS_ADDR_LO_W] : `BBMS_HI_ADDR_ZERO;
      status_out <= nxt_cur.status;
      dout       <= nxt_cur.wdata;
    end
  end

  // Upper address byte is optional on the permanent master, forced on a temporary one.
  assign addr_hi_oe  = own_bus & (mode_temp | ext_addr_en);
  assign stval_n_out = ~ctrl.stval_n_drv;
  assign stval_n_oe  = own_bus & stval_jumper;

  // ----------------------------------------------------------------
  // Temporary master request and arbitration
  // ----------------------------------------------------------------
  logic [`BBMS_PRIO_W-1:0] drive_mask;
  integer i;
  // Open-collector lines: a bit is pulled low only while its mask holds it.
  always_comb begin
    drive_mask = my_prio;
    for (i = `BBMS_PRIO_W - 1; i >= 0; i = i - 1) begin
      if (tma_s[i] && !my_prio[i]) begin
        drive_mask = drive_mask & ~((`BBMS_PRIO_W'(1) << i) - `BBMS_PRIO_W'(1));
      end
    end
  end

  assign hold_n_out = 1'b0;
  assign hold_n_oe  = mode_temp & have_req & (state_ff == BBMS_ARB);
  assign tma_n_out  = '0;
  assign tma_n_oe   = hold_n_oe ? drive_mask : '0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sync_stval;
    @(posedge sys_clk) disable iff (!rst_n)
      !(ctrl.sync && ctrl.stval_n_drv);
  endproperty
  a_sync_stval: assert property (p_sync_stval) else $error("sync and stval together");

  property p_start_next;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BBMS_START && !mode_dummy && !mode_temp) |=> state_ff == BBMS_STABLE;
  endproperty
  a_start_next: assert property (p_start_next) else $error("start not followed by stable");

  property p_abort_nowait;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BBMS_STABLE && cur_ff.abort && !mode_dummy) |=> state_ff == BBMS_XFER;
  endproperty
  a_abort_nowait: assert property (p_abort_nowait) else $error("abort cycle waited");

  property p_notready_wait;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BBMS_STABLE && !cur_ff.abort && !rdy_s && !mode_dummy)
      |=> state_ff == BBMS_WAIT;
  endproperty
  a_notready_wait: assert property (p_notready_wait) else $error("no wait on not ready");

  property p_hold_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BBMS_XFER && hold_take && !mode_dummy) |=> ctrl.hlda;
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("hold not acknowledged");

  property p_hold_stay;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BBMS_HOLD && hold_s) |=> state_ff == BBMS_HOLD;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("left hold early");

  property p_hold_first;
    @(posedge sys_clk) disable iff (!rst_n)
      hold_take |=> !int_accept;
  endproperty
  a_hold_first: assert property (p_hold_first) else $error("interrupt beat hold");

  property p_idle_strobes;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BBMS_IDLE && $past(state_ff) == BBMS_IDLE) |-> !ctrl.wr && !ctrl.dbin;
  endproperty
  a_idle_strobes: assert property (p_idle_strobes) else $error("strobe in idle");

  property p_dummy_null;
    @(posedge sys_clk) disable iff (!rst_n)
      mode_dummy && $past(mode_dummy) |-> !ctrl.sync && !ctrl.wr && !ctrl.dbin;
  endproperty
  a_dummy_null: assert property (p_dummy_null) else $error("dummy ran a cycle");
endmodule
`default_nettype wire
